// ---- src/sar_converter_control.sv ----
// digital control and register file of a 10-bit successive approximation converter
// assumes an analog array that answers each trial code on cmpHigh within a step,
// and an Avalon-MM master on the same clock as this logic
//
// Overview of operation
// [RULE1] above high reference returns code 3FF
// [RULE2] below low reference returns code zero
// [RULE3] sample phase then eight approximation steps
// [RULE4] converter on repeats conversions back to back
// [RULE5] setting on starts converting selected channel
// [RULE6] each completion updates results, sets done
// [RULE7] reading high result clears done flag
// [RULE8] software polls, reads low, then high
// [RULE9] eight-bit users poll then read high
// [RULE10] clearing on switches converter off
// [RULE11] cpu wait leaves conversions untouched
// [RULE12] halt disables; wakeup waits stabilization time
// [RULE13] software configures analog pins as plain inputs
// [RULE14] control layout: done, speed, on, channel
// [RULE15] channel codes zero to four pick inputs
// [RULE16] control write with on aborts, restarts
// [RULE17] high result shows result bits nine to two
// [RULE18] low result: bits one-zero, slow bit three
// [RULE19] slow gives /4, speed gives /1, else /2
// [RULE20] all three registers reset to zero
// [RULE21] phase lengths are design parameters
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none

module sar_converter_control #(
	parameter int SAMPLE_TICKS = sar_pkg::SAMPLE_TICKS,
	parameter int STEP_TICKS   = sar_pkg::STEP_TICKS,
	parameter int STAB_CYCLES  = sar_pkg::STAB_CYCLES
) (
	// clock, reset, freeze
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ce,
	// register bus
	input  wire logic [7:0]           address,
	input  wire logic                 read,
	input  wire logic                 write,
	input  wire logic [31:0]          writedata,
	input  wire logic [3:0]           byteenable,
	output logic      [31:0]          readdata,
	output logic                      waitrequest,
	// cpu power state
	input  wire logic                 cpuHalt,
	// analog array
	input  wire sar_pkg::sar_ana_in_t anaIn,
	output sar_pkg::sar_ana_ctl_t     anaCtl
);

	// refuse lengths the sequencer cannot serve, before anything runs
	if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 256) begin : gBadSample
		$error("SAMPLE_TICKS out of range");
	end
	if (STEP_TICKS < 5 || STEP_TICKS > 256) begin : gBadStep
		$error("STEP_TICKS must cover the input synchroniser");
	end
	if (STAB_CYCLES < 1 || STAB_CYCLES > 65536) begin : gBadStab
		$error("STAB_CYCLES out of range");
	end

	// register word select, shared by read and write decode
	function automatic logic isReg(input logic [7:0] addr, input logic [7:0] idx);
		isReg = (addr == 8'((idx << 2)));
	endfunction

	// state
	sar_pkg::sar_state_t  state_reg;
	sar_pkg::sar_state_t  stateNext;
	logic [7:0]           tick_reg;
	logic [7:0]           tickNext;
	logic [2:0]           step_reg;
	logic [2:0]           stepNext;
	logic [7:0]           dac_reg;
	logic [7:0]           dacNext;
	logic [9:0]           result_reg;
	logic [9:0]           resultNext;
	logic [15:0]          stab_reg;
	logic [15:0]          stabNext;
	logic                 needStab_reg;
	logic                 needStabNext;
	logic                 done_reg;
	logic                 speed_reg;
	logic                 on_reg;
	logic [2:0]           chan_reg;
	logic                 slow_reg;
	logic [1:0]           div_reg;
	logic                 waitReq_reg;
	logic [31:0]          rdata_reg;
	sar_pkg::sar_ana_ctl_t anaCtl_reg;
	logic [4:0]           sync1_reg;
	logic [4:0]           sync2_reg;
	logic [4:0]           sync3_reg;
	logic [4:0]           filt_reg;

	// analog inputs after the synchroniser
	sar_pkg::sar_ana_in_t anaFilt;
	assign anaFilt = sar_pkg::sar_ana_in_t'(filt_reg);

	// three-stage synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			sync3_reg <= 5'h00;
		end else if (ce) begin
			sync1_reg <= anaIn;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// per-bit agreement filter
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : gFilt
			always_ff @(posedge clk) begin
				if (rst)
					filt_reg[gi] <= 1'b0;
				else if (ce && sync2_reg[gi] == sync3_reg[gi])
					filt_reg[gi] <= sync3_reg[gi];
			end
		end
	endgenerate

	// bus handshake: request seen, answer one cycle later, taken on the edge after
	wire reqSeen = (read | write) & waitReq_reg;
	wire accRd   = read & ~waitReq_reg;
	wire accWr   = write & ~waitReq_reg;
	wire lane0   = byteenable[0];
	wire csrWr   = accWr & lane0 & isReg(address, sar_pkg::IDX_CSR);
	wire lowWr   = accWr & lane0 & isReg(address, sar_pkg::IDX_LOW);
	wire hiRd    = accRd & isReg(address, sar_pkg::IDX_HIGH);
	wire wrOn    = csrWr & writedata[sar_pkg::CSR_ON_BIT];

	// read mux; unmapped words read zero
	wire [7:0] csrView  = {done_reg, speed_reg, on_reg, 2'h0, chan_reg};             // [RULE14]
	wire [7:0] highView = result_reg[9:2];                                          // [RULE17]
	wire [7:0] lowView  = {4'h0, slow_reg, 1'b0, result_reg[1:0]};                  // [RULE18]
	wire [7:0] rdByte;
	assign rdByte = isReg(address, sar_pkg::IDX_CSR)  ? csrView  :
	                isReg(address, sar_pkg::IDX_HIGH) ? highView :
	                isReg(address, sar_pkg::IDX_LOW)  ? lowView  : 8'h00;

	// converter clock as an enable: /4 when slow, /1 when speed, else /2
	wire adcTick = slow_reg  ? (div_reg == 2'h3) :                                  // [RULE19]
	               speed_reg ? 1'b1 : div_reg[0];

	// phase boundaries in converter clock ticks
	wire sampleEnd = adcTick & (tick_reg == 8'(SAMPLE_TICKS - 1));                  // [RULE21]
	wire stepEnd   = adcTick & (tick_reg == 8'(STEP_TICKS - 1));                    // [RULE21]
	wire stHold    = (state_reg == sar_pkg::ST_HOLD);
	wire stSample  = (state_reg == sar_pkg::ST_SAMPLE);
	wire stIdle    = (state_reg == sar_pkg::ST_IDLE);
	wire lastStep  = (step_reg == 3'(sar_pkg::SAR_STEPS - 1));
	wire holdEnd   = stHold & stepEnd & lastStep;
	// an abort or halt in the finishing cycle discards the result
	wire doneEvt   = holdEnd & ~csrWr & ~cpuHalt;

	// approximation decision on the current trial bit
	wire [7:0] bitMask  = 8'h80 >> step_reg;
	wire [7:0] decided  = anaFilt.cmpHigh ? dac_reg : (dac_reg & ~bitMask);         // [RULE3]
	wire [9:0] rawCode  = {decided, anaFilt.fineCode};
	wire [9:0] finalCode = anaFilt.overRange  ? sar_pkg::FULL_SCALE :               // [RULE1]
	                       anaFilt.underRange ? sar_pkg::ZERO_SCALE : rawCode;      // [RULE2]

	// first phase after starting; a wakeup from halt waits first
	wire sar_pkg::sar_state_t startState = needStab_reg ? sar_pkg::ST_STAB : sar_pkg::ST_SAMPLE;

	// sequencer next state; no wait input, so cpu wait leaves it running [RULE11]
	always_comb begin
		stateNext    = state_reg;
		tickNext     = tick_reg;
		stepNext     = step_reg;
		dacNext      = dac_reg;
		resultNext   = result_reg;
		stabNext     = stab_reg;
		needStabNext = needStab_reg;
		if (cpuHalt) begin
			stateNext    = sar_pkg::ST_IDLE;                                        // [RULE12]
			needStabNext = 1'b1;
		end else if (csrWr) begin
			tickNext = 8'h00;
			stabNext = 16'h0000;
			stepNext = 3'h0;
			if (wrOn)
				stateNext = startState;                                             // [RULE16]
			else
				stateNext = sar_pkg::ST_IDLE;                                       // [RULE10]
		end else begin
			case (state_reg)
				sar_pkg::ST_IDLE: begin
					if (on_reg) begin
						stateNext = startState;
						tickNext  = 8'h00;
						stabNext  = 16'h0000;
					end
				end
				sar_pkg::ST_STAB: begin
					if (stab_reg == 16'(STAB_CYCLES - 1)) begin
						stateNext    = sar_pkg::ST_SAMPLE;                          // [RULE12]
						needStabNext = 1'b0;
						tickNext     = 8'h00;
					end else
						stabNext = stab_reg + 16'h0001;
				end
				sar_pkg::ST_SAMPLE: begin
					if (sampleEnd) begin
						stateNext = sar_pkg::ST_HOLD;                               // [RULE3]
						tickNext  = 8'h00;
						stepNext  = 3'h0;
						dacNext   = sar_pkg::SAR_FIRST;
					end else if (adcTick)
						tickNext = tick_reg + 8'h01;
				end
				sar_pkg::ST_HOLD: begin
					if (stepEnd) begin
						tickNext = 8'h00;
						dacNext  = decided | (bitMask >> 1);
						if (lastStep) begin
							resultNext = finalCode;                                 // [RULE6]
							stateNext  = sar_pkg::ST_SAMPLE;                        // [RULE4]
							stepNext   = 3'h0;
						end else
							stepNext = step_reg + 3'h1;
					end else if (adcTick)
						tickNext = tick_reg + 8'h01;
				end
				default: stateNext = sar_pkg::ST_IDLE;
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg    <= sar_pkg::ST_IDLE;
			tick_reg     <= 8'h00;
			step_reg     <= 3'h0;
			dac_reg      <= 8'h00;
			result_reg   <= 10'h000;                                                // [RULE20]
			stab_reg     <= 16'h0000;
			needStab_reg <= 1'b0;
			div_reg      <= 2'h0;
		end else if (ce) begin
			state_reg    <= stateNext;
			tick_reg     <= tickNext;
			step_reg     <= stepNext;
			dac_reg      <= dacNext;
			result_reg   <= resultNext;
			stab_reg     <= stabNext;
			needStab_reg <= needStabNext;
			div_reg      <= div_reg + 2'h1;
		end
	end

	// done flag: completion wins over a same-cycle read clear
	wire doneNext = doneEvt ? 1'b1 :                                                // [RULE6]
	                (hiRd | wrOn) ? 1'b0 : done_reg;                                // [RULE7]

	// software fields; reserved bits 4:3 are not stored
	always_ff @(posedge clk) begin
		if (rst) begin
			done_reg  <= 1'b0;                                                      // [RULE20]
			speed_reg <= 1'b0;
			on_reg    <= 1'b0;
			chan_reg  <= 3'h0;
			slow_reg  <= 1'b0;
		end else if (ce) begin
			done_reg <= doneNext;
			if (csrWr) begin
				speed_reg <= writedata[sar_pkg::CSR_SPEED_BIT];                     // [RULE14]
				on_reg    <= writedata[sar_pkg::CSR_ON_BIT];                        // [RULE5]
				chan_reg  <= writedata[sar_pkg::CSR_CHAN_LSB +: 3];                 // [RULE15]
			end
			if (lowWr)
				slow_reg <= writedata[sar_pkg::LOW_SLOW_BIT];                       // [RULE18]
		end
	end

	// bus answer registers
	always_ff @(posedge clk) begin
		if (rst) begin
			waitReq_reg <= 1'b1;
			rdata_reg   <= 32'h0000_0000;
		end else if (ce) begin
			if (reqSeen) begin
				waitReq_reg <= 1'b0;
				rdata_reg   <= {24'h00_0000, rdByte};
			end else
				waitReq_reg <= 1'b1;
		end
	end

	// analog control follows the next state so it lines up with the sequencer
	wire sar_pkg::sar_ana_ctl_t ctlNext = '{
		power:     (stateNext != sar_pkg::ST_IDLE),                                 // [RULE10]
		sample:    (stateNext == sar_pkg::ST_SAMPLE),
		channel:   (csrWr ? writedata[sar_pkg::CSR_CHAN_LSB +: 3] : chan_reg),      // [RULE5]
		trialCode: dacNext
	};

	always_ff @(posedge clk) begin
		if (rst)
			anaCtl_reg <= '0;
		else if (ce)
			anaCtl_reg <= ctlNext;
	end

	// outputs straight from flip-flops
	assign readdata    = rdata_reg;
	assign waitrequest = waitReq_reg;
	assign anaCtl      = anaCtl_reg;

	// checks on the sequencer and register behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	overRange_code_a: assert property (ce && doneEvt && anaFilt.overRange |=> // [RULE1]
		result_reg == 10'h3FF && done_reg)
		else $error("over range did not give full scale");

	underRange_code_a: assert property (ce && doneEvt && anaFilt.underRange && !anaFilt.overRange |=> // [RULE2]
		result_reg == 10'h000)
		else $error("under range did not give zero");

	hold_entry_a: assert property (ce && stSample && sampleEnd && !cpuHalt && !csrWr |=> // [RULE3]
		stHold && dac_reg == 8'h80 && step_reg == 3'h0 && !anaCtl.sample)
		else $error("hold phase entered wrongly");

	continuous_run_a: assert property (ce && doneEvt |=> stSample && anaCtl.sample) // [RULE4]
		else $error("conversion did not restart");

	start_on_a: assert property (ce && wrOn && !cpuHalt |=> // [RULE5]
		!stIdle && anaCtl.power && anaCtl.channel == $past(writedata[2:0]))
		else $error("converter did not start on selected channel");

	done_set_a: assert property (ce && doneEvt |=> done_reg && result_reg == $past(finalCode)) // [RULE6]
		else $error("completion lost");

	read_clear_a: assert property (ce && hiRd && !doneEvt |=> !done_reg) // [RULE7]
		else $error("high read did not clear done");

	off_stops_a: assert property (ce && csrWr && !wrOn |=> stIdle && !anaCtl.power ##1 stIdle && !anaCtl.power) // [RULE10]
		else $error("converter not switched off");

	halt_off_a: assert property (ce && cpuHalt |=> stIdle && !anaCtl.power) // [RULE12]
		else $error("halt did not disable converter");

	abort_restart_a: assert property (ce && wrOn |=> !done_reg && tick_reg == 8'h00 && !stHold) // [RULE16]
		else $error("control write did not abort");

	// read path and switched-off checks
	high_view_a: assert property (ce && accRd && isReg(address, sar_pkg::IDX_HIGH) |-> // [RULE17]
		readdata[7:0] == $past(result_reg[9:2]))
		else $error("high result read wrong bits");

	csr_reserved_a: assert property (ce && accRd && isReg(address, sar_pkg::IDX_CSR) |-> // [RULE14]
		readdata[4:3] == 2'h0)
		else $error("control reserved bits not zero");

	low_layout_a: assert property (ce && accRd && isReg(address, sar_pkg::IDX_LOW) |-> // [RULE18]
		readdata[7:4] == 4'h0 && readdata[2] == 1'b0 && readdata[3] == slow_reg)
		else $error("low result layout wrong");

	upper_zero_a: assert property (ce && !waitrequest |-> readdata[31:8] == 24'h00_0000) // [RULE18]
		else $error("upper read bits not zero");

	off_idle_a: assert property (ce && stIdle && !on_reg && !csrWr && !cpuHalt |=> // [RULE10]
		stIdle && !anaCtl.power)
		else $error("converter left idle while off");

endmodule

`default_nettype wire

// ---- src/sar_pkg.sv ----
// shared constants and carrier types for the successive approximation converter control
// assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus
package sar_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int STAB_TIME_NS  = 1000;
	localparam int STAB_CYCLES   = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_TICKS  = 6;
	localparam int STEP_TICKS    = 6;
	localparam int SAR_STEPS     = 8;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_CSR  = 8'h34;
	localparam logic [7:0] IDX_HIGH = 8'h35;
	localparam logic [7:0] IDX_LOW  = 8'h36;

	// control and status field positions
	localparam int CSR_DONE_BIT  = 7;
	localparam int CSR_SPEED_BIT = 6;
	localparam int CSR_ON_BIT    = 5;
	localparam int CSR_CHAN_LSB  = 0;
	localparam int LOW_SLOW_BIT  = 3;

	// reset and result values
	localparam logic [7:0] REG_RESET   = 8'h00;
	localparam logic [9:0] FULL_SCALE  = 10'h3FF;
	localparam logic [9:0] ZERO_SCALE  = 10'h000;
	localparam logic [7:0] SAR_FIRST   = 8'h80;

	// converter sequencer states
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_STAB   = 4'h2,
		ST_SAMPLE = 4'h4,
		ST_HOLD   = 4'h8
	} sar_state_t;

	// signals coming back from the analog array
	typedef struct packed {
		logic       overRange;
		logic       underRange;
		logic [1:0] fineCode;
		logic       cmpHigh;
	} sar_ana_in_t;

	// signals driving the analog array
	typedef struct packed {
		logic       power;
		logic       sample;
		logic [2:0] channel;
		logic [7:0] trialCode;
	} sar_ana_ctl_t;

endpackage

// ---- verif/sar_analog_model.sv ----
// behavioural analog array: sample-and-hold plus comparator seen from the digital side
// assumes the bench sets the input level and range flags; answers trial codes at once
`timescale 1ns/1ns
`default_nettype none

module sar_analog_model (
	// clock and controls from the converter
	input  wire logic                  clk,
	input  wire sar_pkg::sar_ana_ctl_t anaCtl,
	// analog level chosen by the bench
	input  wire logic [9:0]            level,
	input  wire logic                  above,
	input  wire logic                  below,
	// comparator answers
	output wire sar_pkg::sar_ana_in_t  anaIn
);
	logic noise = 1'b0;
	wire  cmp;

	// comparator is meaningless while off or sampling, so it wanders every cycle
	always @(posedge clk) begin
		noise <= ~noise;
	end

	// pins act as plain inputs: the array only compares, it never drives them
	assign cmp   = (anaCtl.power && !anaCtl.sample) ? (anaCtl.trialCode <= level[9:2]) : noise;
	assign anaIn = '{above, below, level[1:0], cmp};
endmodule

`default_nettype wire

// ---- verif/sar_converter_control_bench.sv ----
// self-checking bench of the converter control: table of conversions, then hand-written cases
// assumes the analog model answers each trial code; all waits are bounded
`timescale 1ns/1ns
`default_nettype none

module sar_converter_control_bench;
	typedef struct {logic [7:0] ctrl; logic slow; logic [9:0] level; logic above; logic below;
		logic [9:0] res; int div;} sar_row_t;
	localparam logic [7:0] A_CSR = 8'hD0;
	localparam logic [7:0] A_HIGH = 8'hD4;
	localparam logic [7:0] A_LOW = 8'hD8;
	localparam int STAB = 30;
	localparam int NCONV = sar_pkg::SAMPLE_TICKS + sar_pkg::SAR_STEPS * sar_pkg::STEP_TICKS;
	logic        clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, cpuHalt = 1'b0, above = 1'b0, below = 1'b0;
	logic        ce = 1'b1;
	logic [7:0]  address = 8'h00;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  byteenable = 4'hF;
	logic [9:0]  level = 10'h000;
	logic [31:0] readdata;
	logic        waitrequest;
	sar_pkg::sar_ana_in_t  anaIn;
	sar_pkg::sar_ana_ctl_t anaCtl;
	int          fails = 0, compares = 0, cyc = 0, t0 = 0, took = 0;
	// ctrl, slow, level, above, below, result, clock divider
	sar_row_t rows[5] = '{'{8'h78, 1'b0, 10'h296, 1'b0, 1'b0, 10'h296, 1},
		'{8'h21, 1'b0, 10'h0F0, 1'b1, 1'b0, 10'h3FF, 2}, '{8'h62, 1'b1, 10'h155, 1'b0, 1'b1, 10'h000, 4},
		'{8'h7B, 1'b0, 10'h001, 1'b0, 1'b0, 10'h001, 1}, '{8'h24, 1'b0, 10'h3FE, 1'b0, 1'b0, 10'h3FE, 2}};

	sar_converter_control #(.STAB_CYCLES(STAB)) dut (.clk(clk), .rst(rst), .ce(ce), .address(address),
		.read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .cpuHalt(cpuHalt), .anaIn(anaIn), .anaCtl(anaCtl));
	sar_analog_model array (.clk(clk), .anaCtl(anaCtl), .level(level), .above(above), .below(below), .anaIn(anaIn));

	// clock and free-running cycle count for conversion timing
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end

	task automatic report_and_stop;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// one Avalon transfer; request held until waitrequest is sampled low, then one idle edge
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic be,
		output logic [31:0] q);
		int n;
		n = 0;
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= {3'h0, be};
		read <= ~wr;
		write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 20) begin
			fails++;
			report_and_stop();
		end
		@(posedge clk);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string w);
		logic [31:0] q;
		access(1'b0, a, 8'h00, 1'b1, q);
		check(w, {24'h0, e}, q);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		access(1'b1, a, d, 1'b1, q);
	endtask

	// poll the done flag, as software does, and note the time since t0
	task automatic wait_done;
		logic [31:0] q;
		int n;
		n = 0;
		q = 32'h0;
		while (q[7] !== 1'b1 && n < 400) begin
			access(1'b0, A_CSR, 8'h00, 1'b1, q);
			n++;
		end
		if (n >= 400) begin
			fails++;
			report_and_stop();
		end
		took = cyc - t0;
	endtask

	initial begin
		logic [31:0] q;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk(A_CSR, 8'h00, "csr reset");
		rd_chk(A_HIGH, 8'h00, "high reset");
		rd_chk(A_LOW, 8'h00, "low reset");
		$display("reset test done");
		// table: each row sets channel, clock rate and input, then reads the result low then high
		foreach (rows[i]) begin
			level <= rows[i].level;
			above <= rows[i].above;
			below <= rows[i].below;
			wr(A_LOW, {4'hF, rows[i].slow, 3'h7});
			wr(A_CSR, rows[i].ctrl);
			t0 = cyc;
			wait_done();
			check("tick rate", 32'h1, {31'h0, took >= NCONV * rows[i].div - 4 && took <= NCONV * rows[i].div + 40});
			check("channel", {29'h0, rows[i].ctrl[2:0]}, {29'h0, anaCtl.channel});
			check("power", 32'h1, {31'h0, anaCtl.power});
			rd_chk(A_CSR, 8'h80 | (rows[i].ctrl & 8'h67), "csr done");
			rd_chk(A_LOW, {4'h0, rows[i].slow, 1'b0, rows[i].res[1:0]}, "low result");
			rd_chk(A_HIGH, rows[i].res[9:2], "high result");
			rd_chk(A_CSR, rows[i].ctrl & 8'h67, "csr cleared");
			$display("row %0d test done", i);
		end
		// converter keeps converting with no further write; only the high byte is read
		wait_done();
		rd_chk(A_HIGH, 8'hFF, "repeat result");
		$display("continuous test done");
		// control write while a result waits clears the flag and restarts
		wait_done();
		wr(A_CSR, 8'h24);
		rd_chk(A_CSR, 8'h24, "abort clears done");
		// unmapped place and a write with byte lane 0 off are both ignored
		wr(8'hDC, 8'hFF);
		rd_chk(8'hDC, 8'h00, "unmapped");
		access(1'b1, A_CSR, 8'h00, 1'b0, q);
		rd_chk(A_CSR, 8'h24, "lane off write");
		$display("refusal test done");
		// halt stops the array; after wakeup the stabilization wait comes first
		cpuHalt <= 1'b1;
		repeat (3) @(posedge clk);
		check("halt power", 32'h0, {31'h0, anaCtl.power});
		cpuHalt <= 1'b0;
		t0 = cyc;
		wait_done();
		check("stab wait", 32'h1, {31'h0, took >= STAB + NCONV * 2 - 4});
		$display("halt test done");
		// switching off: no more conversions, results kept
		wr(A_CSR, 8'h04);
		rd_chk(A_HIGH, 8'hFF, "kept result");
		repeat (300) @(posedge clk);
		check("off power", 32'h0, {31'h0, anaCtl.power});
		rd_chk(A_CSR, 8'h04, "off no done");
		$display("off test done");
		// clock enable low freezes a fresh conversion: no result may appear while held
		wr(A_CSR, 8'h21);
		ce <= 1'b0;
		repeat (300) @(posedge clk);
		check("frozen power", 32'h1, {31'h0, anaCtl.power});
		ce <= 1'b1;
		rd_chk(A_CSR, 8'h21, "frozen no done");
		$display("freeze test done");
		// reset in mid-run while converting: registers back to zero, array off, bus idle
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check("reset power", 32'h0, {31'h0, anaCtl.power});
		check("reset wait", 32'h1, {31'h0, waitrequest});
		rd_chk(A_CSR, 8'h00, "csr mid reset");
		rd_chk(A_HIGH, 8'h00, "high mid reset");
		rd_chk(A_LOW, 8'h00, "low mid reset");
		$display("mid-run reset test done");
		report_and_stop();
	end
endmodule

`default_nettype wire
